//--- rcml_pkg.sv
// Package for the reset control and mode latch block.
// Assumes a single system clock domain at 125 MHz.
package rcml_pkg;
	// Cycles from reset release to first bus cycle
	localparam int unsigned FIRST_CYCLE_DELAY = 10;
	localparam logic [3:0] FIRST_CYCLE_CNT = 4'hA;
	// Breakpoint low hold before release, in cycles
	localparam int unsigned BREAKPOINT_PIN_HOLD_CYCLES = 2;
	// Stretch count; pin and master reset lines stay asserted one cycle longer than this after the cause goes away
	localparam logic [3:0] RESET_STRETCH = 4'h8;
	// Data bus width sampled for mode selection
	localparam int unsigned DATA_W = 16;
	// Boot vector fetch address
	localparam logic [23:0] BOOT_VECTOR_ADDR = 24'h000000;
	// Mode latch reset values (default configuration, lines high)
	localparam logic [15:0] MODE_RESET_VAL = 16'hFFFF;
	// Bit positions inside the mode word
	localparam int unsigned MODE_BOOT_SIZE = 0;
	localparam int unsigned MODE_ARB = 1;
	localparam int unsigned MODE_FC = 2;
	localparam int unsigned MODE_ADDR_LO = 3;
	localparam int unsigned MODE_PORT_E = 8;
	localparam int unsigned MODE_PORT_F = 9;
	localparam int unsigned MODE_RESERVED = 11;
	// Reset values of the cause record and the decoded configuration
	localparam logic [5:0] CAUSE_RESET_VAL = 6'h01;
	localparam logic [10:0] CFG_RESET_VAL = 11'h000;
	// Sequencer states
	typedef enum logic [1:0] {RCML_RUN, RCML_WAIT_BUS, RCML_RESET, RCML_RELEASE} rcml_state_type;
endpackage : rcml_pkg

//--- rcml_reset_ctrl.sv
// Reset control and mode latch: reset cause, three reset lines, mode capture.
// Assumes all inputs are synchronous to clk, which stands for the system clock output.
`timescale 1ns/1ns

// Operation
// - Record reset cause; drive pin, clock-unit and master reset lines.
// - All reset requests sampled and gated by the system clock.
// - Asynchronous sources act at once; synchronous ones wait for bus-cycle end.
// - Bus monitor enabled during synchronous reset, forcing stuck cycles to end.
// - Power-up, watchdog and halt are asynchronous, asserting all three lines.
// - Pin and clock-loss resets synchronous, all lines; test reset skips clock unit.
// - Byte or aligned-word writes in progress finish before synchronous reset.
// - Data lines pulled high during reset; high means default, low selects alternate.
// - Data line 0 low gives 8-bit boot port, high gives 16-bit.
// - Line 1 low gives bus arbitration pins; line 2 low gives function codes.
// - Line n low (3..7) turns chip-selects n+3..6 into address lines.
// - Line 8 low moves strobes, size and acknowledge pins to port E.
// - Line 9 low moves interrupt pins and clock-select pin to port F.
// - Clock-select high uses synthesizer, low uses external clock.
// - Breakpoint low at reset enables background debug, high disables it.
// - First bus cycle starts ten clocks after reset release.
// - Boot chip-select active at release; vectors fetched from address zero.
// - External reset pin synchronised; no clock means no reset yet.
module rcml_reset_ctrl (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reset_pin_n,
	input wire logic power_up_req,
	input wire logic watchdog_timeout,
	input wire logic halt_req,
	input wire logic clock_loss,
	input wire logic test_reset_req,
	input wire logic bus_cycle_active,
	input wire logic bus_cycle_end,
	input wire logic [rcml_pkg::DATA_W-1:0] data_in,
	input wire logic clock_source_select_pin,
	input wire logic breakpoint_pin,
	output logic pin_reset_drive,
	output logic clock_unit_reset,
	output logic master_reset_line,
	output logic bus_monitor_force,
	output logic [5:0] reset_cause,
	output logic [rcml_pkg::DATA_W-1:0] data_pullup_oe,
	output logic boot_port_8bit,
	output logic arb_pins_sel,
	output logic fc_pins_sel,
	output logic [4:0] addr_pins_sel,
	output logic io_port_e_sel,
	output logic io_port_f_sel,
	output logic reserved_mode,
	output logic use_synthesizer,
	output logic bdm_enable,
	output logic boot_chip_select,
	output logic first_bus_cycle_ok
);
	import rcml_pkg::*;

	rcml_state_type state_q, state_d;
	logic [3:0] stretch_q, stretch_d;
	logic [3:0] first_q, first_d;
	logic clk_rst_q, clk_rst_d;
	logic [5:0] cause_q, cause_d;
	logic [10:0] cfg_q;
	logic use_syn_q, bdm_q;
	logic [1:0] breakpoint_pin_hist_q;
	logic reset_pin_q;
	logic pin_q, mst_q, mon_q, boot_q, ok_q;
	logic [15:0] pull_q;

	// Reset source classification
	wire async_req = power_up_req | watchdog_timeout | halt_req;
	wire ext_req = ~reset_pin_q;
	wire sync_full_req = ext_req | clock_loss;
	wire sync_req = sync_full_req | test_reset_req;
	wire bus_idle = ~bus_cycle_active | bus_cycle_end;
	wire any_req = async_req | sync_req;
	wire clk_req = async_req | sync_full_req;
	wire [5:0] cause_now = {test_reset_req, clock_loss, ext_req, halt_req,
		watchdog_timeout, power_up_req};

	// Cumulative chip-select to address conversion, line n low converts n..3
	function automatic logic [4:0] addr_conv(input logic [4:0] lines);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 5; i++) begin
			for (int j = i; j < 5; j++) begin
				r[i] = r[i] | ~lines[j];
			end
		end
		return r;
	endfunction : addr_conv

	// Decoded configuration taken from the data bus, so each output leaves a flop
	wire [10:0] cfg_now = {~data_in[MODE_BOOT_SIZE], ~data_in[MODE_ARB], ~data_in[MODE_FC],
		addr_conv(data_in[MODE_ADDR_LO +: 5]), ~data_in[MODE_PORT_E], ~data_in[MODE_PORT_F],
		~data_in[MODE_RESERVED]};

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		stretch_d = stretch_q;
		first_d = first_q;
		clk_rst_d = clk_rst_q;
		cause_d = cause_q;
		unique case (state_q)
			RCML_RUN: begin
				if (first_q != 4'h0) first_d = first_q - 4'h1;
				if (async_req) begin
					state_d = RCML_RESET;
					cause_d = cause_now;
					clk_rst_d = 1'b1;
					stretch_d = RESET_STRETCH;
				end else if (sync_req) begin
					state_d = RCML_WAIT_BUS;
				end
			end
			RCML_WAIT_BUS: begin
				if (async_req | bus_idle) begin
					state_d = RCML_RESET;
					cause_d = cause_now;
					clk_rst_d = clk_req;
					stretch_d = RESET_STRETCH;
				end else if (!sync_req) begin
					state_d = RCML_RUN;
				end
			end
			RCML_RESET: begin
				cause_d = cause_q | cause_now;
				clk_rst_d = clk_rst_q | clk_req;
				if (any_req) stretch_d = RESET_STRETCH;
				else if (stretch_q != 4'h0) stretch_d = stretch_q - 4'h1;
				else state_d = RCML_RELEASE;
			end
			RCML_RELEASE: begin
				state_d = RCML_RUN;
				clk_rst_d = 1'b0;
				first_d = FIRST_CYCLE_CNT - 4'h1; // Release state is the first of the ten
			end
		endcase
	end

	wire in_reset = (state_q == RCML_RESET);
	wire releasing = (state_q == RCML_RELEASE);

	// Sequencer and line registers, all gated by clk
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= RCML_RESET;
			stretch_q <= RESET_STRETCH;
			first_q <= 4'h0;
			clk_rst_q <= 1'b1;
			cause_q <= CAUSE_RESET_VAL;
			reset_pin_q <= 1'b1;
			pin_q <= 1'b1;
			mst_q <= 1'b1;
			mon_q <= 1'b0;
			boot_q <= 1'b0;
			ok_q <= 1'b0;
			pull_q <= 16'hFFFF;
		end else begin
			state_q <= state_d;
			stretch_q <= stretch_d;
			first_q <= first_d;
			clk_rst_q <= clk_rst_d;
			cause_q <= cause_d;
			reset_pin_q <= reset_pin_n;
			pin_q <= (state_d == RCML_RESET);
			mst_q <= (state_d == RCML_RESET);
			mon_q <= (state_d == RCML_WAIT_BUS);
			boot_q <= (state_d == RCML_RUN) | (state_d == RCML_RELEASE);
			ok_q <= (state_d == RCML_RUN) && (first_d == 4'h0);
			pull_q <= {16{state_d == RCML_RESET}};
		end
	end

	// Breakpoint history and mode capture at release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= CFG_RESET_VAL;
			use_syn_q <= 1'b1;
			bdm_q <= 1'b0;
			breakpoint_pin_hist_q <= 2'h3;
		end else begin
			breakpoint_pin_hist_q <= {breakpoint_pin_hist_q[0], breakpoint_pin};
			if (in_reset && state_d == RCML_RELEASE) begin
				cfg_q <= cfg_now;
				use_syn_q <= clock_source_select_pin;
				bdm_q <= ~breakpoint_pin_hist_q[0] & ~breakpoint_pin;
			end
		end
	end

	assign pin_reset_drive = pin_q;
	assign clock_unit_reset = clk_rst_q;
	assign master_reset_line = mst_q;
	assign bus_monitor_force = mon_q;
	assign reset_cause = cause_q;
	assign data_pullup_oe = pull_q;
	assign boot_port_8bit = cfg_q[10];
	assign arb_pins_sel = cfg_q[9];
	assign fc_pins_sel = cfg_q[8];
	assign addr_pins_sel = cfg_q[7:3];
	assign io_port_e_sel = cfg_q[2];
	assign io_port_f_sel = cfg_q[1];
	assign reserved_mode = cfg_q[0];
	assign use_synthesizer = use_syn_q;
	assign bdm_enable = bdm_q;
	assign boot_chip_select = boot_q;
	assign first_bus_cycle_ok = ok_q;

	// Checks
	property p_async_acts;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_RUN && async_req) |=> (master_reset_line && clock_unit_reset);
	endproperty
	a_async_acts: assert property (p_async_acts) else $error("async reset missed");

	property p_sync_waits;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_WAIT_BUS && !bus_idle && !async_req) |=> !master_reset_line;
	endproperty
	a_sync_waits: assert property (p_sync_waits) else $error("sync reset cut a cycle");

	property p_monitor;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_WAIT_BUS) |-> bus_monitor_force;
	endproperty
	a_monitor: assert property (p_monitor) else $error("bus monitor not on");

	property p_test_no_clk;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_WAIT_BUS && bus_idle && !async_req && !clk_req && test_reset_req)
		|=> (master_reset_line && !clock_unit_reset);
	endproperty
	a_test_no_clk: assert property (p_test_no_clk) else $error("test reset hit clock unit");

	property p_lines_together;
		@(posedge clk) disable iff (!arst_n)
		pin_reset_drive == master_reset_line;
	endproperty
	a_lines_together: assert property (p_lines_together) else $error("reset lines differ");

	property p_first_cycle;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_RELEASE) ##1 (!any_req) [*8] ##1 !any_req
		|-> !first_bus_cycle_ok ##1 first_bus_cycle_ok;
	endproperty
	a_first_cycle: assert property (p_first_cycle) else $error("first cycle timing");

	property p_mode_hold;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_RUN) |=> $stable(cfg_q) && $stable(bdm_enable) && $stable(use_synthesizer);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");

	property p_boot_size;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_RESET && state_d == RCML_RELEASE) |=> boot_port_8bit == !$past(data_in[0]);
	endproperty
	a_boot_size: assert property (p_boot_size) else $error("boot size wrong");

	property p_boot_cs;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_RELEASE) |-> boot_chip_select && !master_reset_line;
	endproperty
	a_boot_cs: assert property (p_boot_cs) else $error("boot select not active");

	property p_pull_in_reset;
		@(posedge clk) disable iff (!arst_n)
		data_pullup_oe == {16{master_reset_line}};
	endproperty
	a_pull_in_reset: assert property (p_pull_in_reset) else $error("pull-ups not with reset");

	property p_cause_set;
		@(posedge clk) disable iff (!arst_n)
		in_reset |=> (reset_cause & $past(cause_now)) == $past(cause_now);
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("reset cause lost");

	property p_bdm_capture;
		@(posedge clk) disable iff (!arst_n)
		(in_reset && state_d == RCML_RELEASE) |=>
		bdm_enable == (!$past(breakpoint_pin) && !$past(breakpoint_pin, 2));
	endproperty
	a_bdm_capture: assert property (p_bdm_capture) else $error("debug mode capture wrong");

	property p_sync_full_clk;
		@(posedge clk) disable iff (!arst_n)
		(state_q == RCML_WAIT_BUS && bus_idle && clk_req) |=> clock_unit_reset;
	endproperty
	a_sync_full_clk: assert property (p_sync_full_clk) else $error("clock unit not reset");

	property p_clk_release;
		@(posedge clk) disable iff (!arst_n)
		releasing |=> !clock_unit_reset && !master_reset_line;
	endproperty
	a_clk_release: assert property (p_clk_release) else $error("lines held after release");

	c_async: cover property (@(posedge clk) disable iff (!arst_n) state_q == RCML_RUN && async_req);
	c_wait: cover property (@(posedge clk) disable iff (!arst_n)
		state_q == RCML_WAIT_BUS ##1 state_q == RCML_WAIT_BUS ##1 state_q == RCML_RESET);
	c_bdm: cover property (@(posedge clk) disable iff (!arst_n) releasing && bdm_enable);
	c_test: cover property (@(posedge clk) disable iff (!arst_n) in_reset && !clock_unit_reset);
endmodule : rcml_reset_ctrl

//--- rcml_board.sv
// Board model: external reset source and mode-select conditioning drivers.
// Assumes the bench chooses which lines to pull low; in_reset is the master reset.
`timescale 1ns/1ns
module rcml_board (
	input wire logic in_reset,
	input wire logic [15:0] mode_low,
	input wire logic pin_req,
	input wire logic ext_clk_req,
	input wire logic dbg_req,
	output logic reset_pin_n,
	output logic [15:0] data_in,
	output logic clock_source_select_pin,
	output logic breakpoint_pin
);
	// Drivers only act during reset, else weak pull-ups hold lines high
	assign data_in = in_reset ? ~mode_low : 16'hFFFF;
	// Clock select driven actively during reset
	assign clock_source_select_pin = in_reset ? ~ext_clk_req : 1'b1;
	// Breakpoint held low over the whole reset, released with it
	assign breakpoint_pin = ~(in_reset & dbg_req);
	// Reset pin, active low
	assign reset_pin_n = ~pin_req;
endmodule : rcml_board

//--- rcml_reset_ctrl_test.sv
// Testbench of the reset control and mode latch.
// Assumes a board model drives data, clock-select, breakpoint and reset pin.
`timescale 1ns/1ns
module rcml_reset_ctrl_test;
	import rcml_pkg::*;
	logic clk, arst_n, bus_cycle_active, bus_cycle_end, ext_clk_req, dbg_req, reset_pin_n;
	logic clock_source_select_pin, breakpoint_pin, pin_reset_drive, clock_unit_reset;
	logic master_reset_line, bus_monitor_force, boot_port_8bit, arb_pins_sel, fc_pins_sel;
	logic io_port_e_sel, io_port_f_sel, reserved_mode, use_synthesizer, bdm_enable;
	logic boot_chip_select, first_bus_cycle_ok;
	logic [5:0] req, reset_cause;
	logic [15:0] mode_low, data_in, data_pullup_oe;
	logic [4:0] addr_pins_sel;
	int bad_count = 0;
	int compares = 0;
	rcml_board board (.in_reset(master_reset_line), .mode_low(mode_low), .pin_req(req[3]),
		.ext_clk_req(ext_clk_req), .dbg_req(dbg_req), .reset_pin_n(reset_pin_n),
		.data_in(data_in), .clock_source_select_pin(clock_source_select_pin),
		.breakpoint_pin(breakpoint_pin));
	rcml_reset_ctrl DUT (.clk(clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n),
		.power_up_req(req[0]), .watchdog_timeout(req[1]), .halt_req(req[2]),
		.clock_loss(req[4]), .test_reset_req(req[5]), .bus_cycle_active(bus_cycle_active),
		.bus_cycle_end(bus_cycle_end), .data_in(data_in),
		.clock_source_select_pin(clock_source_select_pin), .breakpoint_pin(breakpoint_pin),
		.pin_reset_drive(pin_reset_drive), .clock_unit_reset(clock_unit_reset),
		.master_reset_line(master_reset_line), .bus_monitor_force(bus_monitor_force),
		.reset_cause(reset_cause), .data_pullup_oe(data_pullup_oe),
		.boot_port_8bit(boot_port_8bit), .arb_pins_sel(arb_pins_sel),
		.fc_pins_sel(fc_pins_sel), .addr_pins_sel(addr_pins_sel),
		.io_port_e_sel(io_port_e_sel), .io_port_f_sel(io_port_f_sel),
		.reserved_mode(reserved_mode), .use_synthesizer(use_synthesizer),
		.bdm_enable(bdm_enable), .boot_chip_select(boot_chip_select),
		.first_bus_cycle_ok(first_bus_cycle_ok));
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Bounded wait for release, then boot select, first cycle delay, latched modes
	task automatic wait_release;
		int n;
		logic [4:0] a;
		n = 0;
		a = 5'h00;
		while (master_reset_line !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (master_reset_line !== 1'b0) begin
			bad_count++;
			tally_and_finish();
		end
		chk({pin_reset_drive, bus_monitor_force}, 2'h0);
		chk(boot_chip_select, 1'b1);
		chk(data_pullup_oe, 16'h0000);
		n = 0;
		while (first_bus_cycle_ok !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (first_bus_cycle_ok !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		chk(16'(n), 16'(FIRST_CYCLE_DELAY));
		chk(clock_unit_reset, 1'b0);
		for (int k = 0; k < 5; k++)
			if (mode_low[3 + k])
				a = 5'((6'h02 << k) - 6'h01);
		chk({boot_port_8bit, arb_pins_sel, fc_pins_sel, addr_pins_sel, io_port_e_sel,
			io_port_f_sel, reserved_mode, use_synthesizer, bdm_enable},
			{mode_low[0], mode_low[1], mode_low[2], a, mode_low[8], mode_low[9],
			mode_low[11], ~ext_clk_req, dbg_req});
	endtask : wait_release
	// One reset from source set r with a chosen mode setting
	task automatic run_reset(input logic [5:0] r, input logic [15:0] ml, input logic ext,
		input logic dbg);
		mode_low = ml;
		ext_clk_req = ext;
		dbg_req = dbg;
		req = r;
		@(negedge clk);
		if ((r & 6'h07) != 6'h00)
			chk(master_reset_line, 1'b1);
		repeat (4) @(negedge clk);
		chk({master_reset_line, pin_reset_drive}, 2'h3);
		chk(clock_unit_reset, r != 6'h20);
		chk(reset_cause & r, r);
		chk(data_pullup_oe, 16'hFFFF);
		req = 6'h00;
		wait_release();
	endtask : run_reset
	// Synchronous reset waits for the running bus cycle with the monitor on
	task automatic sync_during_bus;
		bus_cycle_active = 1'b1;
		req = 6'h10;
		repeat (4) @(negedge clk);
		chk(bus_monitor_force, 1'b1);
		chk(master_reset_line, 1'b0);
		bus_cycle_active = 1'b0;
		bus_cycle_end = 1'b1;
		@(negedge clk);
		bus_cycle_end = 1'b0;
		repeat (3) @(negedge clk);
		chk(master_reset_line, 1'b1);
		req = 6'h00;
		wait_release();
	endtask : sync_during_bus
	// Asynchronous reset in mid-run brings every output back to its reset value
	task automatic arst_mid_run;
		mode_low = 16'h0000;
		ext_clk_req = 1'b0;
		dbg_req = 1'b0;
		arst_n = 1'b0;
		@(negedge clk);
		chk({master_reset_line, pin_reset_drive, clock_unit_reset}, 3'h7);
		chk(reset_cause, 6'h01);
		chk({boot_chip_select, first_bus_cycle_ok, bdm_enable, use_synthesizer}, 4'h1);
		chk({boot_port_8bit, arb_pins_sel, fc_pins_sel, addr_pins_sel, io_port_e_sel,
			io_port_f_sel, reserved_mode}, 11'h000);
		arst_n = 1'b1;
		wait_release();
	endtask : arst_mid_run
	// Main sequence: power-on reset, every source and mode line, bus wait
	initial begin
		arst_n = 1'b0;
		req = 6'h00;
		mode_low = 16'h0000;
		ext_clk_req = 1'b0;
		dbg_req = 1'b0;
		bus_cycle_active = 1'b0;
		bus_cycle_end = 1'b0;
		repeat (12) @(negedge clk);
		chk(reset_cause, 6'h01);
		arst_n = 1'b1;
		wait_release();
		for (int i = 0; i < 12; i++)
			run_reset(6'h01 << (i % 6), 16'h0001 << i, i[0], i[1]);
		arst_mid_run();
		sync_during_bus();
		tally_and_finish();
	end
endmodule : rcml_reset_ctrl_test
